// ===== acrc_top.sv
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module acrc_top
  import acrc_pkg::*;
#(
  parameter int SHORT_CYC = 4,
  parameter int LONG_CYC  = 24,
  parameter int BIT_CYC   = 1
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hardware_trigger_in,
  input  wire logic        alternate_clock_in,
  input  wire logic        async_converter_clock,
  input  wire logic [9:0]  core_result,
  output logic             core_start,
  output logic             core_low_power,
  output logic             core_long_sample,
  output logic             core_ten_bit,
  output logic [4:0]       core_channel
);
`include "acrc_defs.svh"
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  sc1_reg;
  logic [6:4]  sc2_reg;
  logic [7:0]  cvh_reg;
  logic [7:0]  cvl_reg;
  logic [7:0]  cfg_reg;
  logic [9:0]  res_reg;
  logic        lock_reg;
  logic        hwt_reg;
  logic [7:0]  cnt_reg;
  logic [3:0]  bit_reg;
  logic        armed_reg;
  acrc_state_t state_reg;
  logic [4:0]  awa_reg;
  logic [31:0] wd_reg;
  logic [3:0]  ws_reg;
  logic        awh_reg;
  logic        wh_reg;
  wire         ck_en;
  wire         alt_tick;
  wire         async_tick;
  // ----------------------------------------
  // Clock sources
  // ----------------------------------------
  // Edge pulses only: raw slow clocks never clock flops here
  acrc_sync u_alt (
    .mclk  (mclk),
    .rst   (rst),
    .d_in  (alternate_clock_in),
    .pulse (alt_tick)
  );
  acrc_sync u_async (
    .mclk  (mclk),
    .rst   (rst),
    .d_in  (async_converter_clock),
    .pulse (async_tick)
  );
  acrc_clkdiv u_div (
    .mclk       (mclk),
    .rst        (rst),
    .src_sel    (cfg_reg[1:0]),
    .div_sel    (cfg_reg[6:5]),
    .alt_tick   (alt_tick),
    .async_tick (async_tick),
    .ck_en      (ck_en)
  );
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire       wr_go  = awh_reg && wh_reg && !s_axi_bvalid;
  wire       rd_go  = s_axi_arvalid && s_axi_arready;
  wire [7:0] wbyte  = wd_reg[7:0];
  wire       wlane  = ws_reg[0];
  wire       wr_sc1 = wr_go && wlane && (awa_reg == `ACRC_OFS_SC1);
  wire       wr_sc2 = wr_go && wlane && (awa_reg == `ACRC_OFS_SC2);
  wire       wr_cvh = wr_go && wlane && (awa_reg == `ACRC_OFS_CVH);
  wire       wr_cvl = wr_go && wlane && (awa_reg == `ACRC_OFS_CVL);
  wire       wr_cfg = wr_go && wlane && (awa_reg == `ACRC_OFS_CFG);
  wire       w_map  = (awa_reg <= `ACRC_OFS_CFG) && (awa_reg[1:0] == 2'h0);
  wire       r_map  = (s_axi_araddr <= `ACRC_OFS_CFG) && (s_axi_araddr[1:0] == 2'h0);
  wire       rd_rh  = rd_go && (s_axi_araddr == `ACRC_OFS_RH);
  wire       rd_rl  = rd_go && (s_axi_araddr == `ACRC_OFS_RL);
  wire       mode10 = (cfg_reg[3:2] == `ACRC_MODE_10);
  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  wire off_ch   = (sc1_reg[4:0] == `ACRC_CH_OFF);
  wire hwt_edge = hardware_trigger_in && !hwt_reg;
  wire trig     = sc2_reg[`ACRC_SC2_TRG] ? hwt_edge && !armed_reg : 1'b0;
  wire sw_start = wr_sc1 && (wbyte[4:0] != `ACRC_CH_OFF) && !sc2_reg[`ACRC_SC2_TRG];
  wire sample_done = (cnt_reg == 8'h0);
  wire conv_end = (state_reg == ACRC_CONV) && ck_en && sample_done
                  && (bit_reg == 4'h0);
  wire [9:0] cmp_val = mode10 ? {cvh_reg[1:0], cvl_reg} : {2'h0, cvl_reg};
  wire [9:0] new_res = mode10 ? core_result : {2'h0, core_result[7:0]};
  wire ge      = (new_res >= cmp_val);
  wire cmp_ok  = !sc2_reg[`ACRC_SC2_CFE] || (sc2_reg[`ACRC_SC2_CGT] ? ge : !ge);
  wire load_ok = conv_end && cmp_ok && !(lock_reg && mode10);
  wire again   = sc1_reg[`ACRC_SC1_CONT] && !off_ch;
  wire [7:0] samp_n = cfg_reg[`ACRC_CFG_LS] ? 8'(LONG_CYC) : 8'(SHORT_CYC);
  wire [3:0] bits_n = mode10 ? 4'hA : 4'h8;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ACRC_IDLE;
      cnt_reg   <= 8'h0;
      bit_reg   <= 4'h0;
      armed_reg <= 1'b0;
      hwt_reg   <= 1'b0;
      core_start <= 1'b0;
    end else begin
      hwt_reg    <= hardware_trigger_in;
      core_start <= 1'b0;
      if (wr_sc1) begin
        armed_reg <= 1'b0;
        state_reg <= sw_start ? ACRC_CONV : ACRC_IDLE;
        cnt_reg   <= samp_n;
        bit_reg   <= bits_n;
        core_start <= sw_start;
      end else begin
        case (state_reg)
          ACRC_IDLE: begin
            if (trig && !off_ch) begin
              state_reg  <= ACRC_CONV;
              cnt_reg    <= samp_n;
              bit_reg    <= bits_n;
              core_start <= 1'b1;
              armed_reg  <= sc1_reg[`ACRC_SC1_CONT];
            end
          end
          ACRC_CONV: begin
            if (ck_en) begin
              if (!sample_done) begin
                cnt_reg <= cnt_reg - 8'h1;
              end else if (bit_reg != 4'h0) begin
                bit_reg <= bit_reg - 4'h1;
              end else begin
                state_reg <= ACRC_DONE;
              end
            end
          end
          ACRC_DONE: begin
            state_reg  <= again ? ACRC_CONV : ACRC_IDLE;
            cnt_reg    <= samp_n;
            bit_reg    <= bits_n;
            core_start <= again;
            if (!again) begin
              armed_reg <= 1'b0;
            end
          end
          default: state_reg <= ACRC_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] mode_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sc1_reg  <= 8'h1F;
      sc2_reg  <= 3'h0;
      cvh_reg  <= 8'h00;
      cvl_reg  <= 8'h00;
      cfg_reg  <= 8'h00;
      res_reg  <= 10'h000;
      lock_reg <= 1'b0;
      mode_q   <= 8'h00;
    end else begin
      if (wr_sc1) begin
        sc1_reg[6:0] <= wbyte[6:0];
      end
      // Set wins over clear on reads of the low byte
      if (conv_end && cmp_ok) begin
        sc1_reg[`ACRC_SC1_CONVERSION_COMPLETE_FLAG] <= 1'b1;
      end else if (wr_sc1 || rd_rl) begin
        sc1_reg[`ACRC_SC1_CONVERSION_COMPLETE_FLAG] <= 1'b0;
      end
      // Reserved low bits are dropped on write
      if (wr_sc2) begin
        sc2_reg <= wbyte[6:4];
      end
      if (wr_cvh) begin
        cvh_reg <= {6'h00, wbyte[1:0]};
      end
      if (wr_cvl) begin
        cvl_reg <= wbyte;
      end
      if (wr_cfg) begin
        cfg_reg <= wbyte;
      end
      mode_q <= {6'h00, cfg_reg[3:2]};
      if (mode_q[1:0] != cfg_reg[3:2]) begin
        res_reg  <= 10'h000;
        lock_reg <= 1'b0;
      end else if (load_ok) begin
        res_reg <= new_res;
      end
      if (mode10 && rd_rh) begin
        lock_reg <= 1'b1;
      end else if (rd_rl || !mode10) begin
        lock_reg <= 1'b0;
      end
    end
  end
  wire [7:0] rh_val = mode10 ? {6'h00, res_reg[9:8]} : 8'h00;
  wire       busy   = (state_reg != ACRC_IDLE);
  wire [7:0] sc2_rd = {busy, sc2_reg, 4'h0};
  wire [7:0] rd_mux =
    (s_axi_araddr == `ACRC_OFS_SC1) ? sc1_reg :
    (s_axi_araddr == `ACRC_OFS_SC2) ? sc2_rd :
    (s_axi_araddr == `ACRC_OFS_RH)  ? rh_val :
    (s_axi_araddr == `ACRC_OFS_RL)  ? res_reg[7:0] :
    (s_axi_araddr == `ACRC_OFS_CVH) ? cvh_reg :
    (s_axi_araddr == `ACRC_OFS_CVL) ? cvl_reg : cfg_reg;
  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awh_reg <= 1'b0;
      wh_reg  <= 1'b0;
      awa_reg <= 5'h00;
      wd_reg  <= 32'h0000_0000;
      ws_reg  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ACRC_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ACRC_RESP_OK;
    end else begin
      s_axi_awready <= !awh_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !wh_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awh_reg <= 1'b1;
        awa_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        awh_reg <= 1'b0;
        wh_reg  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? `ACRC_RESP_OK : `ACRC_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= r_map ? {24'h000000, rd_mux} : 32'h0000_0000;
        s_axi_rresp   <= r_map ? `ACRC_RESP_OK : `ACRC_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Converter core controls
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_low_power   <= 1'b0;
      core_long_sample <= 1'b0;
      core_ten_bit     <= 1'b0;
      core_channel     <= 5'h1F;
    end else begin
      core_low_power   <= cfg_reg[`ACRC_CFG_LP];
      core_long_sample <= cfg_reg[`ACRC_CFG_LS];
      core_ten_bit     <= mode10;
      core_channel     <= sc1_reg[4:0];
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_active_busy: assert property (@(posedge mclk) disable iff (rst)
    conv_end && !wr_sc1 |=> busy) else $error("active dropped early");
  chk_load_result: assert property (@(posedge mclk) disable iff (rst)
    load_ok && !wr_cfg && (mode_q[1:0] == cfg_reg[3:2]) |=> res_reg == $past(new_res))
    else $error("result not loaded");
  chk_lock_hold: assert property (@(posedge mclk) disable iff (rst)
    lock_reg && mode10 && !rd_rl && (mode_q[1:0] == cfg_reg[3:2]) |=> $stable(res_reg))
    else $error("locked result changed");
  chk_rh_zero: assert property (@(posedge mclk) disable iff (rst)
    !mode10 |-> rh_val == 8'h00) else $error("high byte nonzero");
  chk_conversion_complete_flag_set: assert property (@(posedge mclk) disable iff (rst)
    conv_end && cmp_ok |=> sc1_reg[`ACRC_SC1_CONVERSION_COMPLETE_FLAG]) else $error("flag not set");
  chk_abort_write: assert property (@(posedge mclk) disable iff (rst)
    wr_sc1 && !sw_start |=> state_reg == ACRC_IDLE) else $error("abort missed");
  chk_cmp_block: assert property (@(posedge mclk) disable iff (rst)
    conv_end && !cmp_ok |=> !$rose(sc1_reg[`ACRC_SC1_CONVERSION_COMPLETE_FLAG])) else $error("false compare");
  chk_lock_8bit: assert property (@(posedge mclk) disable iff (rst)
    !mode10 |=> !lock_reg) else $error("lock in 8-bit");
  cov_conv: cover property (@(posedge mclk) conv_end);
  cov_lock: cover property (@(posedge mclk) lock_reg && conv_end);
  cov_cmp:  cover property (@(posedge mclk) conv_end && !cmp_ok);
  cov_rep:  cover property (@(posedge mclk) (state_reg == ACRC_DONE) && again);
endmodule
`default_nettype wire

// ===== acrc_defs.svh
`ifndef ACRC_DEFS_SVH
`define ACRC_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ACRC_OFS_SC1  5'h00
`define ACRC_OFS_SC2  5'h04
`define ACRC_OFS_RH   5'h08
`define ACRC_OFS_RL   5'h0C
`define ACRC_OFS_CVH  5'h10
`define ACRC_OFS_CVL  5'h14
`define ACRC_OFS_CFG  5'h18
// ----------------------------------------
// Field positions and field values
// ----------------------------------------
`define ACRC_SC1_CONVERSION_COMPLETE_FLAG 7
`define ACRC_SC1_CONT 5
`define ACRC_SC2_ACT  7
`define ACRC_SC2_TRG  6
`define ACRC_SC2_CFE  5
`define ACRC_SC2_CGT  4
`define ACRC_CFG_LP   7
`define ACRC_CFG_LS   4
`define ACRC_CH_OFF   5'h1F
`define ACRC_MODE_8   2'h0
`define ACRC_MODE_10  2'h2
`define ACRC_RESP_OK  2'h0
`define ACRC_RESP_ERR 2'h2
`endif

// ===== acrc_pkg.sv
`default_nettype none
package acrc_pkg;
  typedef enum logic [2:0] {
    ACRC_IDLE = 3'b001,
    ACRC_CONV = 3'b010,
    ACRC_DONE = 3'b100
  } acrc_state_t;
endpackage
`default_nettype wire

// ===== acrc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Converter clock enable: source select then divide
// ----------------------------------------
module acrc_clkdiv (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [1:0] src_sel,
  input  wire logic [1:0] div_sel,
  input  wire logic       alt_tick,
  input  wire logic       async_tick,
  output logic            ck_en
);
  logic       half_reg;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_limit;
  wire        src_tick;
  assign src_tick = (src_sel == 2'h0) ? 1'b1 :
                    (src_sel == 2'h1) ? half_reg :
                    (src_sel == 2'h2) ? alt_tick : async_tick;
  assign cnt_limit = (3'h1 << div_sel) - 3'h1;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      half_reg <= 1'b0;
      cnt_reg  <= 3'h0;
      ck_en    <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      ck_en    <= src_tick && (cnt_reg >= cnt_limit);
      if (src_tick) begin
        cnt_reg <= (cnt_reg >= cnt_limit) ? 3'h0 : cnt_reg + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== acrc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-flop synchroniser plus rising-edge pulse
// ----------------------------------------
module acrc_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic d_in,
  output logic      pulse
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      pulse  <= 1'b0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pulse  <= s2_reg & ~s3_reg;
    end
  end
endmodule
`default_nettype wire

// ===== acrc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Analog core: value latched at each start
// ----------------------------------------
module acrc_core_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       core_start,
  input  wire logic       core_ten_bit,
  input  wire logic [9:0] next_value,
  output logic      [9:0] core_result
);
  // Held until the next start, so the sample point never matters
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_result <= 10'h000;
    end else if (core_start) begin
      core_result <= core_ten_bit ? next_value : {2'b00, next_value[7:0]};
    end
  end
endmodule
`default_nettype wire

// ===== test_adc_config_result_compare.sv
`timescale 1ns/1ps
`default_nettype none
`include "acrc_defs.svh"
module test_adc_config_result_compare;
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} acrc_row_t;
  logic        mclk = 1'b0, rst = 1'b1, hardware_trigger_in = 1'b0;
  logic        alternate_clock_in = 1'b0, async_converter_clock = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [9:0]  next_value = 10'h000;
  logic [3:0]  slow_cnt = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        core_start, core_low_power, core_long_sample, core_ten_bit;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [9:0]  core_result;
  logic [4:0]  core_channel;
  int          miscompares = 0, compares = 0, starts = 0, start_base = 0;
  acrc_row_t   rows[7] = '{'{`ACRC_OFS_CVL, 8'hA5, 8'hA5, 2'h0},
                           '{`ACRC_OFS_CVH, 8'h03, 8'h03, 2'h0},
                           '{`ACRC_OFS_CFG, 8'hF3, 8'hF3, 2'h0},
                           '{`ACRC_OFS_SC2, 8'h30, 8'h30, 2'h0},
                           '{`ACRC_OFS_RH, 8'hFF, 8'h00, 2'h0},
                           '{`ACRC_OFS_RL, 8'hFF, 8'h00, 2'h0},
                           '{5'h1C, 8'h5A, 8'h00, 2'h2}};

  always #2 mclk = ~mclk;
  // Slow sources divided down from the bus clock, changed just after its edge
  always @(posedge mclk) begin
    slow_cnt              <= slow_cnt + 4'h1;
    alternate_clock_in    <= slow_cnt[2];
    async_converter_clock <= slow_cnt[3];
  end
  always @(posedge mclk) if (core_start === 1'b1) starts++;

  acrc_top #(.SHORT_CYC(4), .LONG_CYC(24), .BIT_CYC(1)) acrc_top_inst (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hardware_trigger_in,
    .alternate_clock_in, .async_converter_clock, .core_result, .core_start,
    .core_low_power, .core_long_sample, .core_ten_bit, .core_channel);
  acrc_core_model acrc_core_model_inst (
    .mclk, .rst, .core_start, .core_ten_bit, .next_value, .core_result);

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Ready is registered, so its level at the falling edge is what the next edge samples
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bit ta, tw;
    logic ga, gw;
    ta = 0;
    tw = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge mclk);
      ga = s_axi_awready;
      gw = s_axi_wready;
      @(posedge mclk);
      if (ga === 1'b1 && !ta) begin
        s_axi_awvalid <= 1'b0;
        ta = 1;
      end
      if (gw === 1'b1 && !tw) begin
        s_axi_wvalid <= 1'b0;
        tw = 1;
      end
    end while (!(ta && tw));
    do @(negedge mclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [4:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (s_axi_arready !== 1'b1);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge mclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
    rdr(a);
    chk(nm, rd, {24'h0, e});
  endtask

  task automatic conv(input logic [9:0] v, input bit hw);
    int n, s0;
    s0 = starts;
    next_value <= v;
    wr(`ACRC_OFS_SC1, 8'h00);
    if (hw) begin
      rdr(`ACRC_OFS_SC2);
      chk("idle before trigger", rd[7], 0);
      hardware_trigger_in <= 1'b1;
    end
    rdr(`ACRC_OFS_SC2);
    chk("active set", rd[7], 1);
    n = 0;
    do begin
      rdr(`ACRC_OFS_SC2);
      n++;
    end while (rd[7] === 1'b1 && n < 2000);
    chk("active clear", rd[7], 0);
    chk("one start", starts - s0, 1);
    hardware_trigger_in <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    chk("channel off", core_channel, 5'h1F);
    rc("cfg reset", `ACRC_OFS_CFG, 8'h00);
    rc("sc2 reset", `ACRC_OFS_SC2, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", rsp, rows[i].r);
      rdr(rows[i].a);
      chk("rresp", rsp, rows[i].r);
      chk("rdata", rd, rows[i].e);
    end
    chk("low power", core_low_power, 1);
    chk("long sample", core_long_sample, 1);
    wr(`ACRC_OFS_SC2, 8'h00);
    wr(`ACRC_OFS_CFG, 8'h00);
    // Core controls are registered: look once they have settled
    @(negedge mclk);
    chk("high speed", core_low_power, 0);
    chk("short sample", core_long_sample, 0);
    $display("register table test done");
    for (int i = 0; i < 4; i++) begin
      wr(`ACRC_OFS_CFG, {1'b0, i[1:0], 3'b000, i[1:0]});
      conv(10'h011 + 10'(i), 0);
      rc("source result", `ACRC_OFS_RL, 8'h11 + 8'(i));
    end
    wr(`ACRC_OFS_CFG, 8'h00);
    $display("clock source test done");
    wr(`ACRC_OFS_CVL, 8'h50);
    wr(`ACRC_OFS_SC2, 8'h20);
    conv(10'h060, 0);
    rc("less false kept", `ACRC_OFS_RL, 8'h14);
    rc("flag unset", `ACRC_OFS_SC1, 8'h00);
    conv(10'h040, 0);
    rc("flag set", `ACRC_OFS_SC1, 8'h80);
    rc("less true", `ACRC_OFS_RL, 8'h40);
    rc("flag cleared", `ACRC_OFS_SC1, 8'h00);
    wr(`ACRC_OFS_SC2, 8'h30);
    conv(10'h050, 0);
    rc("ge equal", `ACRC_OFS_RL, 8'h50);
    conv(10'h04F, 0);
    rc("ge false", `ACRC_OFS_RL, 8'h50);
    rc("high 8-bit", `ACRC_OFS_RH, 8'h00);
    wr(`ACRC_OFS_SC2, 8'h00);
    conv(10'h04F, 0);
    rc("compare off", `ACRC_OFS_RL, 8'h4F);
    $display("8-bit compare test done");
    wr(`ACRC_OFS_CFG, 8'h08);
    @(negedge mclk);
    chk("ten bit", core_ten_bit, 1);
    rc("mode change", `ACRC_OFS_RL, 8'h00);
    wr(`ACRC_OFS_CVH, 8'h01);
    wr(`ACRC_OFS_CVL, 8'h80);
    wr(`ACRC_OFS_SC2, 8'h30);
    conv(10'h17F, 0);
    rc("ten bit false", `ACRC_OFS_RL, 8'h00);
    conv(10'h2C5, 0);
    rc("ten bit high", `ACRC_OFS_RH, 8'h02);
    rc("ten bit low", `ACRC_OFS_RL, 8'hC5);
    $display("10-bit compare test done");
    wr(`ACRC_OFS_SC2, 8'h00);
    conv(10'h2AA, 0);
    rc("lock high", `ACRC_OFS_RH, 8'h02);
    conv(10'h155, 0);
    rc("locked low", `ACRC_OFS_RL, 8'hAA);
    conv(10'h155, 0);
    rc("unlocked high", `ACRC_OFS_RH, 8'h01);
    rc("unlocked low", `ACRC_OFS_RL, 8'h55);
    wr(`ACRC_OFS_CFG, 8'h00);
    rc("mode change high", `ACRC_OFS_RH, 8'h00);
    conv(10'h011, 0);
    rc("no lock high", `ACRC_OFS_RH, 8'h00);
    conv(10'h022, 0);
    rc("no lock low", `ACRC_OFS_RL, 8'h22);
    $display("interlock test done");
    start_base = starts;
    wr(`ACRC_OFS_SC1, 8'h20);
    repeat (60) @(posedge mclk);
    chk("continuous repeats", starts - start_base >= 3, 1);
    wr(`ACRC_OFS_SC1, 8'h1F);
    rc("continuous stopped", `ACRC_OFS_SC2, 8'h00);
    start_base = starts;
    repeat (30) @(posedge mclk);
    chk("no restart", starts - start_base, 0);
    $display("continuous test done");
    wr(`ACRC_OFS_SC2, 8'h40);
    conv(10'h033, 1);
    rc("hw result", `ACRC_OFS_RL, 8'h33);
    $display("hardware trigger test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
